// File: design/adc_diag_control_regs.sv
// converter control, diagnostic flag and channel sequencing registers behind the serial port
`timescale 1ns/100ps
module adc_diag_control_regs #(
  parameter int NUM_CHAN = 16,
  parameter int NUM_SETUP = 8,
  parameter logic [23:0] GAIN_DEFAULT = cvt_pkg::GAIN_RESET
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // serial port pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic din_in,
  output logic dout_out,
  output logic dout_en_n_out,
  // converter core events
  input wire logic conv_done_in,
  input wire logic [23:0] conv_data_in,
  input wire logic cal_done_in,
  input wire logic [23:0] cal_coef_in,
  // converter core settings
  output logic [1:0] power_mode_out,
  output logic [3:0] op_mode_out,
  output logic [1:0] clock_select_out,
  output logic ref_enable_out,
  output logic [$clog2(NUM_CHAN)-1:0] active_channel_out,
  output logic [23:0] offset_coef_out,
  output logic [23:0] gain_coef_out,
  output logic error_out
);
  localparam int CW = $clog2(NUM_CHAN);
  localparam int SW = $clog2(NUM_SETUP);

  typedef struct packed {
    cvt_pkg::phase_t phase;
    logic sclk_q;
    logic rd;
    logic bad;
    logic ign;
    logic [5:0] addr;
    logic [5:0] bits;
    logic [5:0] need;
    logic [31:0] shin;
    logic [31:0] shout;
    logic dout;
    logic dout_en_n;
    logic [15:0] control;
    logic [23:0] err_en;
    logic [23:0] err_flags;
    logic status_err;
    logic rdy_n;
    logic [23:0] data;
    logic [7:0] pulses;
    logic [cvt_pkg::DIV_W-1:0] div;
    logic [cvt_pkg::IGN_W-1:0] ignore;
    logic [NUM_CHAN-1:0][15:0] chan;
    logic [NUM_SETUP-1:0][23:0] offset;
    logic [NUM_SETUP-1:0][23:0] gain;
    logic [CW-1:0] active;
    logic [23:0] cur_offset;
    logic [23:0] cur_gain;
  } state_t;
  state_t st;
  state_t next_st;

  logic [2:0] pins;
  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  logic [NUM_CHAN-1:0] chan_en;
  logic [CW-1:0] seq_next;
  logic rise;
  logic fall;
  logic app;
  logic cnt_bad;
  logic bad_rd;
  logic bad_wr;
  logic wr_ign;
  logic err_clear;
  logic pulse_tick;
  logic [7:0] cmd;
  logic [1:0] nbytes;
  logic [23:0] wdata;
  logic [23:0] events;
  logic [7:0] status_b;
  logic [3:0] mode;
  logic [SW-1:0] cal_setup;

  sync2 #(.WIDTH(3), .RESET_VAL(3'h6)) pin_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({sclk_in, cs_n_in, din_in}),
    .sync_out(pins)
  );
  assign {sclk_s, cs_n_s, din_s} = pins;

  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_en
    assign chan_en[g] = st.chan[g][cvt_pkg::CH_EN];
  end

  channel_sequencer #(.NUM_CHAN(NUM_CHAN)) seq (
    .enables_in(chan_en),
    .current_in(st.active),
    .next_out(seq_next)
  );

  // right-aligned contents of a readable register
  function automatic logic [23:0] read_value(input logic [5:0] a);
    logic [23:0] v;
    v = '0;
    if (a == cvt_pkg::A_STATUS) v = 24'(status_b);
    else if (a == cvt_pkg::A_CONTROL) v = 24'(st.control);
    else if (a == cvt_pkg::A_DATA) v = st.data;
    else if (a == cvt_pkg::A_ERRFLAGS) v = st.err_flags;
    else if (a == cvt_pkg::A_ERREN) v = st.err_en;
    else if (a == cvt_pkg::A_PULSES) v = 24'(st.pulses);
    else if (a >= cvt_pkg::A_CHAN0 && a < cvt_pkg::A_CHAN0 + NUM_CHAN) v = 24'(st.chan[CW'(a - cvt_pkg::A_CHAN0)]);
    else if (a >= cvt_pkg::A_OFFSET0 && a < cvt_pkg::A_OFFSET0 + NUM_SETUP) v = st.offset[SW'(a - cvt_pkg::A_OFFSET0)];
    else if (a >= cvt_pkg::A_GAIN0 && a < cvt_pkg::A_GAIN0 + NUM_SETUP) v = st.gain[SW'(a - cvt_pkg::A_GAIN0)];
    return v;
  endfunction: read_value

  always_comb begin
    next_st = st;
    rise = sclk_s & ~st.sclk_q;
    fall = ~sclk_s & st.sclk_q;
    cnt_bad = 1'b0;
    bad_rd = 1'b0;
    bad_wr = 1'b0;
    wr_ign = 1'b0;
    err_clear = 1'b0;
    cmd = {st.shin[6:0], din_s};
    wdata = {st.shin[22:0], din_s};
    nbytes = cvt_pkg::reg_bytes(cmd[5:0]);
    status_b = {st.rdy_n, st.status_err, 6'(st.active)};
    mode = st.control[cvt_pkg::CTL_MODE_LSB +: 4];
    cal_setup = st.chan[st.active][cvt_pkg::CH_SETUP_LSB +: SW];
    pulse_tick = (st.div == cvt_pkg::DIV_W'(cvt_pkg::MCLK_CYCLES - 1));
    app = cmd[cvt_pkg::CMD_RD] && cmd[5:0] == cvt_pkg::A_DATA && st.control[cvt_pkg::CTL_DATA_STATUS];
    next_st.sclk_q = sclk_s;
    // serial frame
    if (cs_n_s) begin
      if ((st.phase == cvt_pkg::PH_CMD || st.phase == cvt_pkg::PH_DATA) && st.bits != st.need) begin
        cnt_bad = 1'b1;
      end
      next_st.phase = cvt_pkg::PH_IDLE;
      next_st.dout_en_n = 1'b1;
      next_st.bits = '0;
    end else if (st.phase == cvt_pkg::PH_IDLE) begin
      next_st.bits = '0;
      next_st.bad = 1'b0;
      // a frame opened inside the reset window has its write dropped
      next_st.ign = (st.ignore != '0);
      next_st.rd = 1'b0;
      next_st.need = 6'(cvt_pkg::CMD_BITS);
      next_st.phase = cvt_pkg::PH_CMD;
      if (st.control[cvt_pkg::CTL_CONT_RD]) begin
        // frame is the result, with the status byte after it when enabled; no command byte
        next_st.phase = cvt_pkg::PH_DATA;
        next_st.rd = 1'b1;
        next_st.addr = cvt_pkg::A_DATA;
        next_st.need = st.control[cvt_pkg::CTL_DATA_STATUS] ? 6'(32) : 6'(24);
        next_st.shout = {st.data, st.control[cvt_pkg::CTL_DATA_STATUS] ? status_b : 8'h00};
        next_st.dout_en_n = 1'b0;
      end
    end else if (rise && st.phase != cvt_pkg::PH_DROP) begin
      next_st.shin = {st.shin[30:0], din_s};
      if (st.bits != 6'h3f) next_st.bits = st.bits + 6'h01;
      if (st.phase == cvt_pkg::PH_CMD && st.bits == st.need - 6'h01) begin
        if (cmd[cvt_pkg::CMD_WEN]) begin
          next_st.phase = cvt_pkg::PH_DROP;
        end else begin
          next_st.phase = cvt_pkg::PH_DATA;
          next_st.addr = cmd[5:0];
          next_st.rd = cmd[cvt_pkg::CMD_RD];
          next_st.need = 6'(8 * (1 + int'(nbytes) + int'(app)));
          if (cmd[cvt_pkg::CMD_RD]) begin
            bad_rd = !cvt_pkg::rd_ok(cmd[5:0]);
            next_st.shout = bad_rd ? '0 : 32'({read_value(cmd[5:0]), app ? status_b : 8'h00} << (8 * (3 - nbytes)));
            next_st.dout_en_n = 1'b0;
          end else begin
            bad_wr = !cvt_pkg::wr_ok(cmd[5:0]);
            next_st.bad = bad_wr;
          end
        end
      end else if (st.phase == cvt_pkg::PH_DATA && st.bits == st.need - 6'h01) begin
        if (st.rd) begin
          err_clear = (st.addr == cvt_pkg::A_ERRFLAGS);
          if (st.addr == cvt_pkg::A_DATA) next_st.rdy_n = 1'b1;
        end else if (!st.bad) begin
          if (st.ign) begin
            wr_ign = 1'b1;
          end else if (st.addr == cvt_pkg::A_CONTROL) begin
            next_st.control = wdata[15:0];
          end else if (st.addr == cvt_pkg::A_ERREN) begin
            next_st.err_en = wdata;
          end else if (st.addr >= cvt_pkg::A_CHAN0 && st.addr < cvt_pkg::A_CHAN0 + NUM_CHAN) begin
            next_st.chan[CW'(st.addr - cvt_pkg::A_CHAN0)] = wdata[15:0];
          end else if (st.addr >= cvt_pkg::A_OFFSET0 && st.addr < cvt_pkg::A_OFFSET0 + NUM_SETUP) begin
            next_st.offset[SW'(st.addr - cvt_pkg::A_OFFSET0)] = wdata;
          end else if (st.addr >= cvt_pkg::A_GAIN0 && st.addr < cvt_pkg::A_GAIN0 + NUM_SETUP) begin
            next_st.gain[SW'(st.addr - cvt_pkg::A_GAIN0)] = wdata;
          end
        end
      end
    end else if (fall && st.phase == cvt_pkg::PH_DATA && st.rd) begin
      next_st.dout = st.shout[31];
      next_st.shout = {st.shout[30:0], 1'b0};
    end
    // converter core
    if (conv_done_in) begin
      next_st.data = conv_data_in;
      next_st.rdy_n = 1'b0;
      if (mode == cvt_pkg::MODE_CONT) next_st.active = seq_next;
    end
    if (cal_done_in && mode >= cvt_pkg::MODE_INT_ZS && mode <= cvt_pkg::MODE_SYS_FS) begin
      if (mode == cvt_pkg::MODE_INT_ZS || mode == cvt_pkg::MODE_SYS_ZS) begin
        next_st.offset[cal_setup] = cal_coef_in;
      end else begin
        next_st.gain[cal_setup] = cal_coef_in;
      end
      next_st.control[cvt_pkg::CTL_MODE_LSB +: 4] = cvt_pkg::MODE_IDLE;
    end
    // pulse monitor and write-ignore window
    next_st.div = pulse_tick ? '0 : cvt_pkg::DIV_W'(st.div + 1'b1);
    if (pulse_tick && st.err_en[cvt_pkg::EN_PULSE_COUNT]) next_st.pulses = st.pulses + 8'h01;
    if (st.ignore != '0) next_st.ignore = st.ignore - 1'b1;
    // diagnostics: a new event wins over a read clear
    events = '0;
    events[cvt_pkg::ERR_IGNORE] = wr_ign;
    events[cvt_pkg::ERR_SCLK] = cnt_bad;
    events[cvt_pkg::ERR_READ] = bad_rd;
    events[cvt_pkg::ERR_WRITE] = bad_wr;
    next_st.err_flags = ((err_clear ? '0 : st.err_flags) | events) & next_st.err_en;
    next_st.status_err = |next_st.err_flags;
    next_st.cur_offset = next_st.offset[next_st.chan[next_st.active][cvt_pkg::CH_SETUP_LSB +: SW]];
    next_st.cur_gain = next_st.gain[next_st.chan[next_st.active][cvt_pkg::CH_SETUP_LSB +: SW]];
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
      st.sclk_q <= 1'b1;
      st.dout_en_n <= 1'b1;
      st.rdy_n <= 1'b1;
      st.control <= cvt_pkg::CONTROL_RESET;
      st.err_en <= cvt_pkg::ERR_EN_RESET;
      st.err_flags <= cvt_pkg::ERR_FLAGS_RESET;
      st.pulses <= cvt_pkg::PULSES_RESET;
      st.ignore <= cvt_pkg::IGN_W'(cvt_pkg::IGNORE_CYCLES);
      for (int i = 0; i < NUM_CHAN; i++) begin
        st.chan[i] <= (i == 0) ? cvt_pkg::CHAN0_RESET : cvt_pkg::CHAN_RESET;
      end
      for (int i = 0; i < NUM_SETUP; i++) begin
        st.offset[i] <= cvt_pkg::OFFSET_RESET;
        st.gain[i] <= GAIN_DEFAULT;
      end
      st.cur_offset <= cvt_pkg::OFFSET_RESET;
      st.cur_gain <= GAIN_DEFAULT;
    end else begin
      st <= next_st;
    end
  end

  assign dout_out = st.dout;
  assign dout_en_n_out = st.dout_en_n;
  assign power_mode_out = st.control[cvt_pkg::CTL_POWER_LSB +: 2];
  assign op_mode_out = st.control[cvt_pkg::CTL_MODE_LSB +: 4];
  assign clock_select_out = st.control[cvt_pkg::CTL_CLK_LSB +: 2];
  assign ref_enable_out = st.control[cvt_pkg::CTL_REF_EN];
  assign active_channel_out = st.active;
  assign offset_coef_out = st.cur_offset;
  assign gain_coef_out = st.cur_gain;
  assign error_out = st.status_err;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  flag_gate_a: assert property ((st.err_flags & ~st.err_en) == '0)
    else $error("flag set while its check is off");
  err_or_a: assert property (|st.err_flags |-> st.status_err && error_out)
    else $error("status error bit misses a flag");
  en_reset_a: assert property ($past(rst_in) |-> st.err_en == cvt_pkg::ERR_EN_RESET && st.err_flags == '0)
    else $error("enable or flag reset value wrong");
  ctl_reset_a: assert property ($past(rst_in) |-> st.control == '0 && st.pulses == '0)
    else $error("control or pulse count not zero after reset");
  off_reset_a: assert property ($past(rst_in) |-> st.offset[0] == cvt_pkg::OFFSET_RESET)
    else $error("offset coefficient reset value wrong");
  ignore_flag_a: assert property (wr_ign && st.err_en[cvt_pkg::ERR_IGNORE] |=> st.err_flags[cvt_pkg::ERR_IGNORE])
    else $error("ignored write not flagged");
  bad_write_a: assert property (bad_wr && st.err_en[cvt_pkg::ERR_WRITE] |=> st.err_flags[cvt_pkg::ERR_WRITE])
    else $error("invalid write not flagged");
  bad_read_a: assert property (bad_rd && st.err_en[cvt_pkg::ERR_READ] |=> st.err_flags[cvt_pkg::ERR_READ])
    else $error("invalid read not flagged");
  sclk_count_a: assert property (cnt_bad && st.err_en[cvt_pkg::ERR_SCLK] |=> st.err_flags[cvt_pkg::ERR_SCLK])
    else $error("wrong clock count not flagged");
  pulse_count_a: assert property (pulse_tick && st.err_en[cvt_pkg::EN_PULSE_COUNT] |=> st.pulses == $past(st.pulses) + 8'h01)
    else $error("pulse count did not step");
  seq_enabled_a: assert property (conv_done_in && mode == cvt_pkg::MODE_CONT && chan_en != '0 |=> chan_en[st.active])
    else $error("sequencer stopped on a disabled channel");
  cal_offset_a: assert property (cal_done_in && mode == cvt_pkg::MODE_INT_ZS |=> st.offset[$past(cal_setup)] == $past(cal_coef_in))
    else $error("calibration offset not stored");

  cal_cov: cover property (cal_done_in && mode == cvt_pkg::MODE_INT_FS);
  wrap_cov: cover property (conv_done_in && mode == cvt_pkg::MODE_CONT && seq_next < st.active);
  count_cov: cover property (cnt_bad ##1 st.err_flags[cvt_pkg::ERR_SCLK]);
endmodule: adc_diag_control_regs

// File: design/channel_sequencer.sv
// next enabled channel in ascending order with wrap
`timescale 1ns/100ps
module channel_sequencer #(
  parameter int NUM_CHAN = 16
) (
  // channel enables and position
  input wire logic [NUM_CHAN-1:0] enables_in,
  input wire logic [$clog2(NUM_CHAN)-1:0] current_in,
  // next channel
  output logic [$clog2(NUM_CHAN)-1:0] next_out
);
  localparam int IW = $clog2(NUM_CHAN);

  // smallest forward step to an enabled channel wins; stays put when none
  always_comb begin
    next_out = current_in;
    for (int i = NUM_CHAN - 1; i >= 1; i--) begin
      if (enables_in[IW'((int'(current_in) + i) % NUM_CHAN)]) begin
        next_out = IW'((int'(current_in) + i) % NUM_CHAN);
      end
    end
  end
endmodule: channel_sequencer

// File: design/cvt_pkg.sv
// register map, field positions, reset values and timing of the converter control registers
package cvt_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int IGNORE_TIME_NS = 2000;
  localparam int IGNORE_CYCLES = (IGNORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MCLK_PERIOD_NS = 1000;
  localparam int MCLK_CYCLES = MCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int IGN_W = $clog2(IGNORE_CYCLES + 1);
  localparam int DIV_W = $clog2(MCLK_CYCLES);
  localparam int CMD_BITS = 8;
  // register addresses
  localparam logic [5:0] A_STATUS = 6'h00;
  localparam logic [5:0] A_CONTROL = 6'h01;
  localparam logic [5:0] A_DATA = 6'h02;
  localparam logic [5:0] A_IOCON2 = 6'h04;
  localparam logic [5:0] A_ID = 6'h05;
  localparam logic [5:0] A_ERRFLAGS = 6'h06;
  localparam logic [5:0] A_ERREN = 6'h07;
  localparam logic [5:0] A_PULSES = 6'h08;
  localparam logic [5:0] A_CHAN0 = 6'h09;
  localparam logic [5:0] A_FILTER0 = 6'h21;
  localparam logic [5:0] A_OFFSET0 = 6'h29;
  localparam logic [5:0] A_GAIN0 = 6'h31;
  localparam logic [5:0] A_LAST = 6'h38;
  // reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [23:0] ERR_FLAGS_RESET = 24'h00_0000;
  localparam logic [23:0] ERR_EN_RESET = 24'h00_0040;
  localparam logic [7:0] PULSES_RESET = 8'h00;
  localparam logic [15:0] CHAN0_RESET = 16'h8001;
  localparam logic [15:0] CHAN_RESET = 16'h0001;
  localparam logic [23:0] OFFSET_RESET = 24'h80_0000;
  localparam logic [23:0] GAIN_RESET = 24'h50_0000;
  // error flag and enable bit positions
  localparam int ERR_IGNORE = 6;
  localparam int ERR_SCLK = 5;
  localparam int ERR_READ = 4;
  localparam int ERR_WRITE = 3;
  localparam int EN_PULSE_COUNT = 22;
  // control fields
  localparam int CTL_CLK_LSB = 0;
  localparam int CTL_MODE_LSB = 2;
  localparam int CTL_POWER_LSB = 6;
  localparam int CTL_REF_EN = 8;
  localparam int CTL_DATA_STATUS = 10;
  localparam int CTL_CONT_RD = 11;
  // channel and command fields
  localparam int CH_EN = 15;
  localparam int CH_SETUP_LSB = 12;
  localparam int CMD_WEN = 7;
  localparam int CMD_RD = 6;
  // operating modes
  localparam logic [3:0] MODE_CONT = 4'h0;
  localparam logic [3:0] MODE_IDLE = 4'h4;
  localparam logic [3:0] MODE_INT_ZS = 4'h5;
  localparam logic [3:0] MODE_INT_FS = 4'h6;
  localparam logic [3:0] MODE_SYS_ZS = 4'h7;
  localparam logic [3:0] MODE_SYS_FS = 4'h8;

  typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA, PH_DROP} phase_t;

  function automatic logic [1:0] reg_bytes(input logic [5:0] a);
    if (a == A_STATUS || a == A_ID || a == A_PULSES) return 2'h1;
    if (a == A_CONTROL || a == A_IOCON2 || (a >= A_CHAN0 && a < A_FILTER0)) return 2'h2;
    return 2'h3;
  endfunction: reg_bytes

  function automatic logic rd_ok(input logic [5:0] a);
    return a <= A_LAST;
  endfunction: rd_ok

  function automatic logic wr_ok(input logic [5:0] a);
    return a <= A_LAST && !(a == A_STATUS || a == A_DATA || a == A_ID || a == A_ERRFLAGS || a == A_PULSES);
  endfunction: wr_ok
endpackage: cvt_pkg

// File: design/sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pin side
  input wire logic [WIDTH-1:0] async_in,
  // clock side
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;
  sync_t st;
  sync_t next_st;

  always_comb begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= {RESET_VAL, RESET_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;
endmodule: sync2

// File: verification/adc_diag_control_regs_test.sv
// self-checking bench of the converter control and diagnostic registers
`timescale 1ns/100ps
module adc_diag_control_regs_test;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sclk, cs_n, din, dout, dout_en_n, ref_enable, error;
  logic conv_done = 1'b0;
  logic cal_done = 1'b0;
  logic [23:0] conv_data = 24'h00_0000;
  logic [23:0] cal_coef = 24'h00_0000;
  logic [1:0] power_mode, clock_select;
  logic [3:0] op_mode, act;
  logic [23:0] offset_coef, gain_coef, v, o;
  logic [39:0] rx;
  logic [31:0] seed = 32'h0000_4d68;
  logic [39:0] fault_tx [3] = '{40'h00_0612_3456, 40'h00_7f00_0000, 40'h00_0000_0410};
  logic [3:0] seq_tab [5] = '{4'h1, 4'h3, 4'h6, 4'h1, 4'h3};
  int fail_count = 0;
  int checks_done = 0;

  always #10 clk_in = ~clk_in;

  adc_diag_control_regs adc_diag_control_regs_inst (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .din_in(din), .dout_out(dout), .dout_en_n_out(dout_en_n), .conv_done_in(conv_done),
    .conv_data_in(conv_data), .cal_done_in(cal_done), .cal_coef_in(cal_coef), .power_mode_out(power_mode),
    .op_mode_out(op_mode), .clock_select_out(clock_select), .ref_enable_out(ref_enable),
    .active_channel_out(act), .offset_coef_out(offset_coef), .gain_coef_out(gain_coef), .error_out(error));
  spi_host_model spi_host_model_inst (.clk_in(clk_in), .dout_in(dout), .dout_en_n_in(dout_en_n),
    .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction: xs

  // register width in bytes by address
  function automatic int nb(input logic [5:0] a);
    if (a == 6'h00 || a == 6'h05 || a == 6'h08) return 1;
    if (a == 6'h01 || a == 6'h04 || (a >= 6'h09 && a <= 6'h18)) return 2;
    return 3;
  endfunction: nb

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask: check

  task automatic tally_and_finish();
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask: tally_and_finish

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [39:0] r;
    spi_host_model_inst.xfer(8 + 8 * nb(a), (40'(a) << (8 * nb(a))) | 40'(d), r);
  endtask: wr

  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    logic [39:0] r;
    spi_host_model_inst.xfer(8 + 8 * nb(a), 40'({2'b01, a}) << (8 * nb(a)), r);
    d = r[23:0] & ((24'h00_0001 << (8 * nb(a))) - 24'h00_0001);
  endtask: rd

  // one-cycle core event: conversion when cv is set, calibration otherwise
  task automatic pulse(input logic cv, input logic [23:0] d);
    @(posedge clk_in);
    conv_done <= cv;
    cal_done <= !cv;
    conv_data <= d;
    cal_coef <= d;
    @(posedge clk_in);
    conv_done <= 1'b0;
    cal_done <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask: pulse

  initial begin
    repeat (100000) @(posedge clk_in);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({power_mode, op_mode, clock_select, ref_enable}, 9'h000);
    check({offset_coef, error}, {24'h80_0000, 1'b0});
    rd(6'h07, v);
    check(v, 24'h00_0040);
    rd(6'h01, v);
    check(v, 24'h00_0000);
    rd(6'h08, v);
    check(v, 24'h00_0000);
    rd(6'h06, v);
    check(v, 24'h00_0000);
    repeat (100) @(posedge clk_in);
    wr(6'h07, 24'h00_0078);
    rd(6'h07, v);
    check(v, 24'h00_0078);
    // bad write, bad read address, short frame
    for (int k = 0; k < 3; k++) begin
      spi_host_model_inst.xfer(k == 2 ? 12 : 32, fault_tx[k], rx);
      if (k == 1) check(rx[23:0], 24'h00_0000);
      check(error, 1'b1);
      rd(6'h06, v);
      check(v, 24'h00_0008 << k);
      check(error, 1'b0);
    end
    wr(6'h07, 24'h00_0000);
    wr(6'h00, 24'h00_00a5);
    check(error, 1'b0);
    rd(6'h06, v);
    check(v, 24'h00_0000);
    wr(6'h07, 24'h00_0008);
    for (int k = 0; k < 5; k++) begin
      seed = xs(seed);
      v = {13'h0000, seed[10], 1'b0, seed[8], 2'(seed[7:6] % 3), 4'(k), seed[1:0]};
      wr(6'h01, v);
      check({power_mode, op_mode, clock_select, ref_enable}, {v[7:6], v[5:2], v[1:0], v[8]});
      rd(6'h01, o);
      check(o, v);
    end
    seed = xs(seed);
    o = seed[23:0];
    wr(6'h09, 24'h00_0001);
    wr(6'h0a, 24'h00_8001);
    wr(6'h0c, 24'h00_a001);
    wr(6'h0f, 24'h00_a001);
    wr(6'h2b, o);
    wr(6'h01, 24'h00_0400);
    wr(6'h00, 24'h00_0000);
    for (int k = 0; k < 5; k++) begin
      seed = xs(seed);
      pulse(1'b1, seed[23:0]);
      check(act, seq_tab[k]);
      check(offset_coef, seq_tab[k] == 4'h1 ? 24'h80_0000 : o);
    end
    spi_host_model_inst.xfer(40, 40'h42_0000_0000, rx);
    check(rx[31:0], {seed[23:0], 8'h43});
    wr(6'h01, 24'h00_0014);
    seed = xs(seed);
    pulse(1'b0, seed[23:0]);
    check({op_mode, offset_coef}, {cvt_pkg::MODE_IDLE, seed[23:0]});
    rd(6'h2b, v);
    check(v, seed[23:0]);
    wr(6'h01, 24'h00_0018);
    pulse(1'b0, o);
    check({op_mode, gain_coef}, {cvt_pkg::MODE_IDLE, o});
    wr(6'h07, 24'h40_0000);
    repeat (1000) @(posedge clk_in);
    rd(6'h08, v);
    check(v >= 24'h00_0014 && v <= 24'h00_0028, 1'b1);
    // continuous read with status: frame carries data and status only
    wr(6'h01, 24'h00_0c00);
    seed = xs(seed);
    pulse(1'b1, seed[23:0]);
    check(act, 4'h6);
    spi_host_model_inst.xfer(32, 40'h00_0000_0000, rx);
    check(rx[31:0], {seed[23:0], 8'h06});
    // reset in mid-run, then a write inside the ignore window
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    wr(6'h01, 24'h00_0041);
    check({power_mode, op_mode, clock_select, ref_enable}, 9'h000);
    check(error, 1'b1);
    rd(6'h06, v);
    check(v, 24'h00_0040);
    tally_and_finish();
  end
endmodule: adc_diag_control_regs_test

// File: verification/spi_host_model.sv
// host side serial port model: mode 3 frames, msb first
`timescale 1ns/100ps
module spi_host_model (
  // clock
  input wire logic clk_in,
  // device pins
  input wire logic dout_in,
  input wire logic dout_en_n_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out
);
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end
  // one frame of n rising edges; tx msb at bit n-1, rx gathers dout before each rise
  task automatic xfer(input int n, input logic [39:0] tx, output logic [39:0] rx);
    rx = 40'h00_0000_0000;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    for (int i = n - 1; i >= 0; i--) begin
      sclk_out <= 1'b0;
      din_out <= tx[i];
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      rx = {rx[38:0], dout_en_n_in ? 1'b0 : dout_in};
      @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (6) @(posedge clk_in);
    end
    cs_n_out <= 1'b1;
    din_out <= ~din_out;
    repeat (8) @(posedge clk_in);
  endtask: xfer
endmodule: spi_host_model
